// file: hw/cgl_glue_top.sv
// Glue logic cells behind a Wishbone register slave.
// Assumes a single clock, synchronous inputs and a classic Wishbone master.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module cgl_glue_top
    import cgl_pkg::*;
#(
    parameter int VEC_COUNT = CGL_VEC_COUNT_DEF,
    parameter int RED_COUNT = CGL_RED_COUNT_DEF,
    parameter int CONST_WIDTH = CGL_CONST_WIDTH_DEF,
    parameter logic [31:0] CONST_VALUE = CGL_CONST_VALUE_DEF,
    parameter int CAT_PORTS = CGL_CAT_PORTS_DEF,
    parameter int CAT_W0 = CGL_CAT_W_DEF,
    parameter int CAT_W1 = CGL_CAT_W_DEF,
    parameter int CAT_W2 = CGL_CAT_W_DEF,
    parameter int CAT_W3 = CGL_CAT_W_DEF,
    parameter int SLICE_INPUT_WIDTH = CGL_SLICE_IN_W_DEF,
    parameter int SLICE_HIGH_BIT = CGL_SLICE_HI_DEF,
    parameter int SLICE_LOW_BIT = CGL_SLICE_LO_DEF,
    localparam int CAT_TOTAL = CAT_W0 + ((CAT_PORTS > 1) ? CAT_W1 : 0)
                               + ((CAT_PORTS > 2) ? CAT_W2 : 0)
                               + ((CAT_PORTS > 3) ? CAT_W3 : 0),
    localparam int SLICE_OUTPUT_WIDTH = SLICE_HIGH_BIT - SLICE_LOW_BIT + 1
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [CGL_ADR_W-1:0] wb_adr_in,
    input wire logic [CGL_SEL_W-1:0] wb_sel_in,
    input wire logic [CGL_DAT_W-1:0] wb_dat_in,
    output logic [CGL_DAT_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [VEC_COUNT-1:0] vec_a_in,
    input wire logic [VEC_COUNT-1:0] vec_b_in,
    input wire logic [RED_COUNT-1:0] red_bits_in,
    input wire logic [CAT_W0-1:0] cat_src0_in,
    input wire logic [CAT_W1-1:0] cat_src1_in,
    input wire logic [CAT_W2-1:0] cat_src2_in,
    input wire logic [CAT_W3-1:0] cat_src3_in,
    input wire logic [SLICE_INPUT_WIDTH-1:0] slice_bus_in,
    output logic [VEC_COUNT-1:0] vec_result_out,
    output logic red_result_out,
    output logic [CONST_WIDTH-1:0] constant_output,
    output logic [CAT_TOTAL-1:0] cat_bus_out,
    output logic [SLICE_OUTPUT_WIDTH-1:0] slice_out
);

    // Build-time checks; readback limits every cell to one bus word
    if (VEC_COUNT > CGL_DAT_W || RED_COUNT > CGL_DAT_W) begin : g_bad_width
        $error("vector or reduction cell wider than a bus word");
    end
    if (CONST_WIDTH < 1 || CONST_WIDTH > CGL_DAT_W) begin : g_bad_const
        $error("constant width out of range");
    end
    if (CAT_PORTS < 1 || CAT_PORTS > CGL_CAT_MAX_PORTS || CAT_TOTAL > CGL_DAT_W)
    begin : g_bad_cat
        $error("concat port count or total width out of range");
    end
    if (SLICE_LOW_BIT < 0 || SLICE_HIGH_BIT < SLICE_LOW_BIT
        || SLICE_HIGH_BIT >= SLICE_INPUT_WIDTH || SLICE_INPUT_WIDTH > CGL_DAT_W)
    begin : g_bad_slice
        $error("slice bounds lie outside the input bus");
    end

    // Register storage
    cgl_ctrl_s ctrl_q;
    logic [31:0] vec_a_q;
    logic [31:0] vec_b_q;
    logic [31:0] red_in_q;
    logic [31:0] slice_in_q;
    logic ack_q;
    logic [31:0] dat_q;

    // Bus decode
    wire bus_req = wb_cyc_in && wb_stb_in;
    wire bus_wr = bus_req && wb_we_in && ack_q;
    wire wr_ctrl = bus_wr && (wb_adr_in == CGL_CTRL_OFS);
    wire wr_vec_a = bus_wr && (wb_adr_in == CGL_VEC_A_OFS);
    wire wr_vec_b = bus_wr && (wb_adr_in == CGL_VEC_B_OFS);
    wire wr_red = bus_wr && (wb_adr_in == CGL_RED_IN_OFS);
    wire wr_slice = bus_wr && (wb_adr_in == CGL_SLICE_IN_OFS);

    // Control write; an illegal reduction code keeps the old mode
    wire [31:0] ctrl_merged = cgl_merge({27'h0, ctrl_q}, wb_dat_in, wb_sel_in);
    wire [1:0] red_code_new = ctrl_merged[3:2];
    wire cgl_red_mode_e red_mode_new = (red_code_new == 2'b11) ? ctrl_q.red_mode
                                     : cgl_red_mode_e'(red_code_new);
    wire cgl_ctrl_s ctrl_d = '{src_pins: ctrl_merged[4],
                              red_mode: red_mode_new,
                              vec_mode: cgl_vec_mode_e'(ctrl_merged[1:0])};

    // Operand selection: pins from neighbouring logic, or registers
    wire [VEC_COUNT-1:0] op_a = ctrl_q.src_pins ? vec_a_in : vec_a_q[VEC_COUNT-1:0];
    wire [VEC_COUNT-1:0] op_b = ctrl_q.src_pins ? vec_b_in : vec_b_q[VEC_COUNT-1:0];
    wire [RED_COUNT-1:0] red_src = ctrl_q.src_pins ? red_bits_in
                                                   : red_in_q[RED_COUNT-1:0];
    wire [SLICE_INPUT_WIDTH-1:0] slice_src = ctrl_q.src_pins ? slice_bus_in
                                           : slice_in_q[SLICE_INPUT_WIDTH-1:0];

    // Cell outputs before the output flops
    logic [VEC_COUNT-1:0] vec_d;
    logic red_d;
    logic [CAT_TOTAL-1:0] cat_d;

    cgl_vector_logic #(
        .ELEMENT_COUNT(VEC_COUNT)
    ) u_vec (
        .mode_in(ctrl_q.vec_mode),
        .vec_a_in(op_a),
        .vec_b_in(op_b),
        .vec_out(vec_d)
    );

    cgl_reduce_logic #(
        .ELEMENT_COUNT(RED_COUNT)
    ) u_red (
        .mode_in(ctrl_q.red_mode),
        .bits_in(red_src),
        .result_out(red_d)
    );

    // Concatenation, first source in the lowest bits
    if (CAT_PORTS == 1) begin : g_cat1
        assign cat_d = cat_src0_in;
    end else if (CAT_PORTS == 2) begin : g_cat2
        assign cat_d = {cat_src1_in, cat_src0_in};
    end else if (CAT_PORTS == 3) begin : g_cat3
        assign cat_d = {cat_src2_in, cat_src1_in, cat_src0_in};
    end else begin : g_cat4
        assign cat_d = {cat_src3_in, cat_src2_in, cat_src1_in, cat_src0_in};
    end

    // Slice range; its width follows from the bounds alone
    wire [SLICE_OUTPUT_WIDTH-1:0] slice_pick = slice_src[SLICE_HIGH_BIT:SLICE_LOW_BIT];
    wire [CONST_WIDTH-1:0] const_val = CONST_VALUE[CONST_WIDTH-1:0];

    // Register writes land on the edge that the master sees ack
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            ctrl_q <= cgl_ctrl_s'(CGL_CTRL_RST);
            vec_a_q <= CGL_DATA_RST;
            vec_b_q <= CGL_DATA_RST;
            red_in_q <= CGL_DATA_RST;
            slice_in_q <= CGL_DATA_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= ctrl_d;
            if (wr_vec_a) vec_a_q <= cgl_merge(vec_a_q, wb_dat_in, wb_sel_in);
            if (wr_vec_b) vec_b_q <= cgl_merge(vec_b_q, wb_dat_in, wb_sel_in);
            if (wr_red) red_in_q <= cgl_merge(red_in_q, wb_dat_in, wb_sel_in);
            if (wr_slice) slice_in_q <= cgl_merge(slice_in_q, wb_dat_in, wb_sel_in);
        end
    end

    // Readback mux; unmapped offsets answer with zero
    logic [31:0] rd_data;
    always_comb begin
        unique case (wb_adr_in)
            CGL_CTRL_OFS: rd_data = {27'h0, ctrl_q};
            CGL_VEC_A_OFS: rd_data = vec_a_q;
            CGL_VEC_B_OFS: rd_data = vec_b_q;
            CGL_VEC_RES_OFS: rd_data = 32'(vec_result_out);
            CGL_RED_IN_OFS: rd_data = red_in_q;
            CGL_RED_RES_OFS: rd_data = {31'h0, red_result_out};
            CGL_CONST_OFS: rd_data = 32'(constant_output);
            CGL_CAT_RES_OFS: rd_data = 32'(cat_bus_out);
            CGL_SLICE_IN_OFS: rd_data = slice_in_q;
            CGL_SLICE_RES_OFS: rd_data = 32'(slice_out);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // One wait state; ack drops the cycle after it was given
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            ack_q <= 1'b0;
            dat_q <= CGL_DATA_RST;
        end else begin
            ack_q <= bus_req && !ack_q;
            dat_q <= (bus_req && !ack_q && !wb_we_in) ? rd_data : 32'h0000_0000;
        end
    end

    // Output flops; one cycle of latency buys clean timing to neighbours
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            vec_result_out <= '0;
            red_result_out <= 1'b0;
            constant_output <= const_val;
            cat_bus_out <= '0;
            slice_out <= '0;
        end else begin
            vec_result_out <= vec_d;
            red_result_out <= red_d;
            constant_output <= const_val;
            cat_bus_out <= cat_d;
            slice_out <= slice_pick;
        end
    end

    assign wb_dat_out = dat_q;
    assign wb_ack_out = ack_q;

    // Checks on the cells and the bus
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ack_then_drop;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    property p_vec_and;
        ctrl_q.vec_mode == CGL_VEC_AND |=>
            vec_result_out == ($past(op_a) & $past(op_b));
    endproperty
    a_vec_and: assert property (p_vec_and) else $error("vector AND wrong");

    property p_vec_or;
        ctrl_q.vec_mode == CGL_VEC_OR |=>
            vec_result_out == ($past(op_a) | $past(op_b));
    endproperty
    a_vec_or: assert property (p_vec_or) else $error("vector OR wrong");

    property p_vec_xor;
        ctrl_q.vec_mode == CGL_VEC_XOR |=>
            vec_result_out == ($past(op_a) ^ $past(op_b));
    endproperty
    a_vec_xor: assert property (p_vec_xor) else $error("vector XOR wrong");

    property p_vec_not;
        ctrl_q.vec_mode == CGL_VEC_NOT |=> vec_result_out == ~$past(op_a);
    endproperty
    a_vec_not: assert property (p_vec_not) else $error("vector NOT wrong");

    property p_red_and;
        ctrl_q.red_mode == CGL_RED_AND |=> red_result_out == &$past(red_src);
    endproperty
    a_red_and: assert property (p_red_and) else $error("reduce AND wrong");

    property p_red_xor;
        ctrl_q.red_mode == CGL_RED_XOR |=> red_result_out == ^$past(red_src);
    endproperty
    a_red_xor: assert property (p_red_xor) else $error("reduce XOR wrong");

    property p_red_or;
        ctrl_q.red_mode == CGL_RED_OR |=> red_result_out == |$past(red_src);
    endproperty
    a_red_or: assert property (p_red_or) else $error("reduce OR wrong");

    // A reserved reduction code must leave the running function alone
    property p_red_keep;
        wr_ctrl && wb_sel_in[0] && wb_dat_in[3:2] == 2'b11 |=> ctrl_q.red_mode == $past(ctrl_q.red_mode);
    endproperty
    a_red_keep: assert property (p_red_keep) else $error("reserved reduce code taken");

    // Read data stays at zero outside the ack cycle
    property p_dat_idle;
        !wb_ack_out |-> wb_dat_out == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    property p_const;
        constant_output == CONST_VALUE[CONST_WIDTH-1:0];
    endproperty
    a_const: assert property (p_const) else $error("constant changed");

    property p_cat_low;
        1'b1 |=> cat_bus_out[CAT_W0-1:0] == $past(cat_src0_in);
    endproperty
    a_cat_low: assert property (p_cat_low) else $error("concat order wrong");

    property p_slice;
        1'b1 |=> slice_out == $past(slice_pick) && $bits(slice_out) == SLICE_OUTPUT_WIDTH;
    endproperty
    a_slice: assert property (p_slice) else $error("slice range wrong");

    property p_ctrl_write;
        wr_ctrl && wb_sel_in[0] |=> ctrl_q.vec_mode == $past(wb_dat_in[1:0])
            ##1 ctrl_q.vec_mode == $past(ctrl_q.vec_mode) || $past(wr_ctrl);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("mode write lost");

    property p_wb_ack;
        s_req |=> s_ack_then_drop;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

endmodule : cgl_glue_top

// file: hw/cgl_pkg.sv
// Shared constants, modes and carriers for the glue logic cells.
// Assumes a single clock domain and a classic Wishbone register bus.
package cgl_pkg;

    // Register bus geometry
    localparam int CGL_ADR_W = 8;
    localparam int CGL_DAT_W = 32;
    localparam int CGL_SEL_W = 4;

    // Register byte offsets
    localparam logic [7:0] CGL_CTRL_OFS = 8'h00;
    localparam logic [7:0] CGL_VEC_A_OFS = 8'h04;
    localparam logic [7:0] CGL_VEC_B_OFS = 8'h08;
    localparam logic [7:0] CGL_VEC_RES_OFS = 8'h0c;
    localparam logic [7:0] CGL_RED_IN_OFS = 8'h10;
    localparam logic [7:0] CGL_RED_RES_OFS = 8'h14;
    localparam logic [7:0] CGL_CONST_OFS = 8'h18;
    localparam logic [7:0] CGL_CAT_RES_OFS = 8'h1c;
    localparam logic [7:0] CGL_SLICE_IN_OFS = 8'h20;
    localparam logic [7:0] CGL_SLICE_RES_OFS = 8'h24;

    // Values after reset
    localparam logic [31:0] CGL_DATA_RST = 32'h0000_0000;
    localparam logic [4:0] CGL_CTRL_RST = 5'h00;

    // Default cell shapes
    localparam int CGL_VEC_COUNT_DEF = 4;
    localparam int CGL_VEC_MIN = 1;
    localparam int CGL_RED_COUNT_DEF = 8;
    localparam int CGL_RED_MIN = 2;
    localparam int CGL_CONST_WIDTH_DEF = 1;
    localparam logic [31:0] CGL_CONST_VALUE_DEF = 32'h0000_0001;
    localparam int CGL_CAT_MAX_PORTS = 4;
    localparam int CGL_CAT_PORTS_DEF = 2;
    localparam int CGL_CAT_W_DEF = 8;
    localparam int CGL_SLICE_IN_W_DEF = 8;
    localparam int CGL_SLICE_HI_DEF = 7;
    localparam int CGL_SLICE_LO_DEF = 0;

    typedef enum logic [1:0] {
        CGL_VEC_AND = 2'b00,
        CGL_VEC_OR = 2'b01,
        CGL_VEC_XOR = 2'b10,
        CGL_VEC_NOT = 2'b11
    } cgl_vec_mode_e;

    typedef enum logic [1:0] {
        CGL_RED_AND = 2'b00,
        CGL_RED_OR = 2'b01,
        CGL_RED_XOR = 2'b10
    } cgl_red_mode_e;

    // Control register layout, bit 4 down to bit 0
    typedef struct packed {
        logic src_pins;
        cgl_red_mode_e red_mode;
        cgl_vec_mode_e vec_mode;
    } cgl_ctrl_s;

    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] cgl_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : cgl_merge

endpackage : cgl_pkg

// file: hw/cgl_vector_logic.sv
// Bitwise vector logic cell: one gate per bit position.
// Assumes the mode input is stable for the whole cycle.
`timescale 1ns/100ps
module cgl_vector_logic
    import cgl_pkg::*;
#(
    parameter int ELEMENT_COUNT = CGL_VEC_COUNT_DEF
) (
    input wire cgl_vec_mode_e mode_in,
    input wire logic [ELEMENT_COUNT-1:0] vec_a_in,
    input wire logic [ELEMENT_COUNT-1:0] vec_b_in,
    output logic [ELEMENT_COUNT-1:0] vec_out
);

    // Any width of one or more is legal
    if (ELEMENT_COUNT < CGL_VEC_MIN) begin : g_bad_count
        $error("vector cell needs at least one element");
    end

    // Independent gate per bit; inversion ignores the second operand
    for (genvar i = 0; i < ELEMENT_COUNT; i++) begin : g_gate
        assign vec_out[i] = (mode_in == CGL_VEC_AND) ? (vec_a_in[i] & vec_b_in[i]) :
                            (mode_in == CGL_VEC_OR) ? (vec_a_in[i] | vec_b_in[i]) :
                            (mode_in == CGL_VEC_XOR) ? (vec_a_in[i] ^ vec_b_in[i]) :
                            ~vec_a_in[i];
    end

endmodule : cgl_vector_logic

// file: hw/cgl_reduce_logic.sv
// Reduction cell: one wide gate across all input bits.
// Assumes the mode input holds a legal code; others give zero.
`timescale 1ns/100ps
module cgl_reduce_logic
    import cgl_pkg::*;
#(
    parameter int ELEMENT_COUNT = CGL_RED_COUNT_DEF
) (
    input wire cgl_red_mode_e mode_in,
    input wire logic [ELEMENT_COUNT-1:0] bits_in,
    output logic result_out
);

    // A single input is no reduction, so refuse it
    if (ELEMENT_COUNT < CGL_RED_MIN) begin : g_bad_count
        $error("reduction cell needs at least two inputs");
    end

    // One gate, one output bit
    assign result_out = (mode_in == CGL_RED_AND) ? (&bits_in) :
                        (mode_in == CGL_RED_OR) ? (|bits_in) :
                        (mode_in == CGL_RED_XOR) ? (^bits_in) :
                        1'b0;

endmodule : cgl_reduce_logic

// file: verification/cgl_far_model.sv
// Behavioural model of the neighbouring logic that feeds the cell pins.
// Assumes the bench hands it one pattern word; every source is cut from it.
`timescale 1ns/100ps
module cgl_far_model #(
    parameter int VEC_W = 4,
    parameter int RED_W = 8
) (
    input wire logic ref_clk_in,
    input wire logic [31:0] pattern_in,
    output logic [VEC_W-1:0] vec_a_out,
    output logic [VEC_W-1:0] vec_b_out,
    output logic [RED_W-1:0] red_bits_out,
    output logic [3:0] cat_src0_out,
    output logic [7:0] cat_src1_out,
    output logic [7:0] cat_src2_out,
    output logic [7:0] cat_src3_out,
    output logic [7:0] slice_bus_out
);
    // Registered like a real upstream flop stage, so sources move after an edge
    always_ff @(posedge ref_clk_in) begin
        vec_a_out <= pattern_in[VEC_W-1:0];
        vec_b_out <= pattern_in[VEC_W+3:4];
        red_bits_out <= pattern_in[RED_W+7:8];
        cat_src0_out <= pattern_in[3:0];
        cat_src1_out <= pattern_in[15:8];
        cat_src2_out <= pattern_in[23:16];
        cat_src3_out <= pattern_in[31:24]; // Unused port, still toggled
        slice_bus_out <= pattern_in[23:16];
    end
endmodule : cgl_far_model

// file: verification/tb_top.sv
// Self-checking bench for the glue cells behind the Wishbone slave.
// Assumes the far model feeds the pins; one clock, synchronous reset.
`timescale 1ns/100ps
module tb_top;
    import cgl_pkg::*;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000, pattern = 32'h0000_0000, rd;
    logic [31:0] wb_dat_out;
    logic wb_ack_out, red_result_out;
    logic [3:0] vec_a, vec_b, vec_result_out, src0;
    logic [5:0] slice_out;
    logic [7:0] red_bits, src1, src2, src3, slice_bus;
    logic [4:0] constant_output;
    logic [19:0] cat_bus_out;
    logic [3:0] vexp [4] = '{4'h8, 4'he, 4'h6, 4'h3};
    logic [7:0] rin [3] = '{8'hff, 8'hfe, 8'h00};
    logic rexp;
    int err_total = 0;
    int num_checks = 0;

    // 200 MHz clock
    always #2.5 ref_clk_in = ~ref_clk_in;

    cgl_far_model u_far (.ref_clk_in(ref_clk_in), .pattern_in(pattern), .vec_a_out(vec_a),
        .vec_b_out(vec_b), .red_bits_out(red_bits), .cat_src0_out(src0), .cat_src1_out(src1),
        .cat_src2_out(src2), .cat_src3_out(src3), .slice_bus_out(slice_bus));

    // Odd shapes on purpose: 5-bit constant, three uneven sources, offset slice
    // Few overrides, so the default widths and the default high bound stay in play
    cgl_glue_top #(.CONST_WIDTH(5), .CONST_VALUE(32'h0000_001e), .CAT_PORTS(3), .CAT_W0(4),
        .SLICE_LOW_BIT(2)) u_dut (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
        .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .vec_a_in(vec_a), .vec_b_in(vec_b), .red_bits_in(red_bits), .cat_src0_in(src0),
        .cat_src1_in(src1), .cat_src2_in(src2), .cat_src3_in(src3),
        .slice_bus_in(slice_bus), .vec_result_out(vec_result_out),
        .red_result_out(red_result_out), .constant_output(constant_output),
        .cat_bus_out(cat_bus_out), .slice_out(slice_out));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Classic single cycle; waits for ack, never assumes its latency
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hf;
        wb_dat <= dat;
        @(posedge ref_clk_in);
        while (wb_ack_out !== 1'b1 && n < 20) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (wb_ack_out !== 1'b1) begin
            err_total++;
            $display("mismatch ack_wait expected 1 seen timeout");
            complete_run();
        end else begin
            rd = wb_dat_out;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
        end
    endtask : wb_cycle

    // Let the committed write reach the registered outputs
    task automatic settle();
        repeat (2) @(posedge ref_clk_in);
    endtask : settle

    initial begin
        repeat (3) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        // Reset values, constant cell, unmapped place
        wb_cycle(1'b0, CGL_CTRL_OFS, 32'h0);
        check("ctrl_rst", rd, 32'h0);
        wb_cycle(1'b0, 8'h40, 32'h0);
        check("unmapped", rd, 32'h0);
        check("constant", constant_output, 32'h1e);
        $display("test reset done");
        // Register operands through all four vector modes
        wb_cycle(1'b1, CGL_VEC_A_OFS, 32'hc);
        wb_cycle(1'b1, CGL_VEC_B_OFS, 32'ha);
        for (int m = 0; m < 4; m++) begin
            wb_cycle(1'b1, CGL_CTRL_OFS, m);
            settle();
            check("vec_pin", vec_result_out, vexp[m]);
            wb_cycle(1'b0, CGL_VEC_RES_OFS, 32'h0);
            check("vec_reg", rd, vexp[m]);
        end
        // Read-only result is not overwritten
        wb_cycle(1'b1, CGL_VEC_RES_OFS, 32'hffff_ffff);
        wb_cycle(1'b0, CGL_VEC_RES_OFS, 32'h0);
        check("vec_ro", rd, 32'h3);
        $display("test vector done");
        // All reduction functions on all-ones, one zero and all-zeros
        for (int m = 0; m < 3; m++) begin
            wb_cycle(1'b1, CGL_CTRL_OFS, m << 2);
            for (int i = 0; i < 3; i++) begin
                wb_cycle(1'b1, CGL_RED_IN_OFS, rin[i]);
                settle();
                rexp = (m == 0) ? &rin[i] : (m == 1) ? |rin[i] : ^rin[i];
                check("red_pin", red_result_out, rexp);
                wb_cycle(1'b0, CGL_RED_RES_OFS, 32'h0);
                check("red_reg", rd, rexp);
            end
        end
        // Reserved reduction code keeps old mode, vector field still taken
        wb_cycle(1'b1, CGL_CTRL_OFS, 32'h0000_000e);
        wb_cycle(1'b0, CGL_CTRL_OFS, 32'h0);
        check("ctrl_red3", rd, 32'h0000_000a);
        $display("test reduce done");
        // Slice from its register: bits 7 down to 2 of b4
        wb_cycle(1'b1, CGL_SLICE_IN_OFS, 32'hb4);
        settle();
        check("slice_reg", slice_out, 32'h2d);
        wb_cycle(1'b0, CGL_SLICE_RES_OFS, 32'h0);
        check("slice_rd", rd, 32'h2d);
        // Pin sources with XOR on both cells
        wb_cycle(1'b1, CGL_CTRL_OFS, 32'h0000_001a);
        for (int k = 0; k < 3; k++) begin
            pattern <= {8'h5a, 8'h96, 8'h3c, 8'h00} ^ (32'h1357_9bdf << k);
            repeat (3) @(posedge ref_clk_in);
            check("vec_src", vec_result_out, pattern[3:0] ^ pattern[7:4]);
            check("red_src", red_result_out, ^pattern[15:8]);
            check("cat", cat_bus_out, {pattern[23:16], pattern[15:8], pattern[3:0]});
            check("slice_src", slice_out, pattern[23:18]);
        end
        wb_cycle(1'b0, CGL_CAT_RES_OFS, 32'h0);
        check("cat_rd", rd, {pattern[23:16], pattern[15:8], pattern[3:0]});
        check("constant_end", constant_output, 32'h1e);
        $display("test pins done");
        // Mid-run reset: mode and operand registers fall back, constant holds
        resetn_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        check("constant_rst", constant_output, 32'h1e);
        wb_cycle(1'b0, CGL_CTRL_OFS, 32'h0);
        check("ctrl_mid", rd, 32'h0);
        wb_cycle(1'b0, CGL_SLICE_IN_OFS, 32'h0);
        check("slice_in_mid", rd, 32'h0);
        wb_cycle(1'b0, CGL_CONST_OFS, 32'h0);
        check("const_rd", rd, 32'h1e);
        $display("test reset again done");
        complete_run();
    end
endmodule : tb_top
